// ==== core/srsc_pkg.sv ====
// constants for the serdes receive status and counter block
package srsc_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PARTNER = 6'h1a;
	localparam logic [5:0] IDX_STATUS  = 6'h1b;
	localparam logic [5:0] IDX_GOOD    = 6'h1c;
	localparam logic [5:0] IDX_ERROR   = 6'h1d;
	localparam logic [5:0] IDX_INT_STS = 6'h1e;
	localparam logic [5:0] IDX_INT_MSK = 6'h1f;
	localparam logic [1:0] WORD_ALIGN  = 2'h0;

	// status register fields
	localparam int ST_REALIGN = 15;
	localparam int ST_SIGDET  = 14;
	localparam int ST_FAULT   = 13;
	localparam int ST_COMMA   = 12;
	localparam int ST_POS_HI  = 11;
	localparam int ST_POS_LO  = 8;
	localparam int ST_HALT    = 7;

	// good and error counter fields
	localparam int GC_SINCE  = 15;
	localparam int GC_W      = 14;
	localparam int EC_W      = 8;
	localparam int SEL_HI    = 15;
	localparam int SEL_LO    = 14;
	localparam logic [GC_W-1:0] GOOD_LIMIT = 14'h2710;
	localparam logic [GC_W-1:0] GOOD_LAST  = GOOD_LIMIT - 14'h0001;
	localparam logic [EC_W-1:0] ERR_MAX    = 8'hff;

	// counter source select codes
	localparam logic [1:0] SEL_MEDIA = 2'h0;
	localparam logic [1:0] SEL_MAC   = 2'h1;

	// interrupt status and mask layout
	localparam int IRQ_W      = 5;
	localparam int IB_REALIGN = 0;
	localparam int IB_FAULT   = 1;
	localparam int IB_HALT    = 2;
	localparam int IB_CRC_ERR = 3;
	localparam int IB_PKT     = 4;

	// reset values
	localparam logic [15:0]      CW_RST  = 16'h0000;
	localparam logic [3:0]       POS_RST = 4'h0;
	localparam logic [1:0]       SEL_RST = 2'h0;
	localparam logic [IRQ_W-1:0] MSK_RST = 5'h00;
	localparam logic [31:0]      RD_RST  = 32'h0000_0000;
endpackage

// ==== core/srsc_sticky.sv ====
// one sticky flag; a set in the same cycle as a clear wins
`timescale 1ns/1ps
module srsc_sticky (
	input  wire logic clock,
	input  wire logic rst_sync_b,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	// set has priority so no event is lost on a clearing access
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule

// ==== core/srsc_top.sv ====
// serdes receive status, event flags and crc packet counters behind apb
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - last configuration code word from partner readable in a 16-bit register
// - status bit 15 flags comma realignment, clears on status read
// - status bit 14 latches signal detect, clears after read
// - status bit 13 flags far-end fault received since last read
// - status bit 12 clears while no comma, set to one by a read
// - status bits 11:8 show comma alignment position 0 to 9
// - status bit 7 flags halt line state seen since last read
// - good counter bit 15 flags any good-crc packet since last read, resets zero
// - 14-bit good-crc counter wraps to zero at 10000 packets
// - good counter clears on read, giving count since previous read
// - 8-bit crc error counter saturates at 0xff, read clears it
// - select 00 picks media serdes, 01 mac serdes, others reserved
// - counters advance only while media link is up
module srsc_top
	import srsc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        cw_valid,
	input  wire logic [15:0] cw_data,
	input  wire logic        comma_realign,
	input  wire logic        signal_detect,
	input  wire logic        far_end_fault_indication,
	input  wire logic        comma_detect,
	input  wire logic [3:0]  comma_pos,
	input  wire logic        halt_line_state,
	input  wire logic        media_link_up,
	input  wire logic        media_pkt_good,
	input  wire logic        media_pkt_crc_err,
	input  wire logic        mac_pkt_good,
	input  wire logic        mac_pkt_crc_err
);
	localparam int NFLAG = IRQ_W + 5;
	localparam int F_REALIGN = IRQ_W;
	localparam int F_SIGDET  = IRQ_W + 1;
	localparam int F_FAULT   = IRQ_W + 2;
	localparam int F_HALT    = IRQ_W + 3;
	localparam int F_SINCE   = IRQ_W + 4;

	logic             rst_meta_b;
	logic             rst_sync_b;
	logic             hit_p;
	logic             hit_s;
	logic             hit_g;
	logic             hit_e;
	logic             hit_i;
	logic             hit_m;
	logic             hit_any;
	logic             setup;
	logic             wr_done;
	logic             rd_take;
	logic             rd_status;
	logic             rd_good;
	logic             rd_err;
	logic [15:0]      rd_val;
	logic [15:0]      cw_r;
	logic [3:0]       pos_r;
	logic             comma_r;
	logic [1:0]       sel_r;
	logic [GC_W-1:0]  good_cnt_r;
	logic [EC_W-1:0]  err_cnt_r;
	logic [IRQ_W-1:0] mask_r;
	logic [IRQ_W-1:0] int_sts;
	logic             good_ev;
	logic             err_ev;
	logic [NFLAG-1:0] flag_set;
	logic [NFLAG-1:0] flag_clr;
	logic [NFLAG-1:0] flag_q;

	//////////////////////////////////////////////////////////////////////
	// reset release: asynchronous assert, two-flop synchronous release
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// apb decode; only word-aligned addresses hit a register
	assign hit_p   = (paddr[7:2] == IDX_PARTNER) && (paddr[1:0] == WORD_ALIGN);
	assign hit_s   = (paddr[7:2] == IDX_STATUS) && (paddr[1:0] == WORD_ALIGN);
	assign hit_g   = (paddr[7:2] == IDX_GOOD) && (paddr[1:0] == WORD_ALIGN);
	assign hit_e   = (paddr[7:2] == IDX_ERROR) && (paddr[1:0] == WORD_ALIGN);
	assign hit_i   = (paddr[7:2] == IDX_INT_STS) && (paddr[1:0] == WORD_ALIGN);
	assign hit_m   = (paddr[7:2] == IDX_INT_MSK) && (paddr[1:0] == WORD_ALIGN);
	assign hit_any = hit_p | hit_s | hit_g | hit_e | hit_i | hit_m;

	// read side effects fire at the setup edge, when the data is sampled,
	// so the value returned and the value cleared are the same snapshot
	assign setup     = psel & ~penable;
	assign wr_done   = psel & penable & pready & pwrite;
	assign rd_take   = setup & ~pwrite;
	assign rd_status = rd_take & hit_s;
	assign rd_good   = rd_take & hit_g;
	assign rd_err    = rd_take & hit_e;

	// read data mux; unlisted bit positions stay zero
	always_comb begin
		rd_val = 16'h0000;
		if (hit_p) begin
			rd_val = cw_r;
		end else if (hit_s) begin
			rd_val[ST_REALIGN]          = flag_q[F_REALIGN];
			rd_val[ST_SIGDET]           = flag_q[F_SIGDET];
			rd_val[ST_FAULT]            = flag_q[F_FAULT];
			rd_val[ST_COMMA]            = comma_r;
			rd_val[ST_POS_HI:ST_POS_LO] = pos_r;
			rd_val[ST_HALT]             = flag_q[F_HALT];
		end else if (hit_g) begin
			rd_val[GC_SINCE]  = flag_q[F_SINCE];
			rd_val[GC_W-1:0]  = good_cnt_r;
		end else if (hit_e) begin
			rd_val[SEL_HI:SEL_LO] = sel_r;
			rd_val[EC_W-1:0]      = err_cnt_r;
		end else if (hit_i) begin
			rd_val[IRQ_W-1:0] = int_sts;
		end else if (hit_m) begin
			rd_val[IRQ_W-1:0] = mask_r;
		end
	end

	// no wait state: answer in the first access cycle
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RD_RST;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit_any;
			if (setup) begin
				prdata <= pwrite ? RD_RST : {16'h0000, rd_val};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// partner code word, captured whenever the receiver delivers one
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cw_r <= CW_RST;
		end else if (cw_valid) begin
			cw_r <= cw_data;
		end
	end

	// comma position follows the aligner live
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pos_r <= POS_RST;
		end else begin
			pos_r <= comma_pos;
		end
	end

	// comma detect: read forces one, absence of comma drops it
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			comma_r <= 1'b0;
		end else if (rd_status) begin
			comma_r <= 1'b1;
		end else if (!comma_detect) begin
			comma_r <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// counter source select; reserved codes are refused, old value kept
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sel_r <= SEL_RST;
		end else if (wr_done && hit_e && (pwdata[SEL_HI:SEL_LO] == SEL_MEDIA ||
			pwdata[SEL_HI:SEL_LO] == SEL_MAC)) begin
			sel_r <= pwdata[SEL_HI:SEL_LO];
		end
	end

	// packet events from the selected serdes, gated by media link
	always_comb begin
		good_ev = 1'b0;
		err_ev  = 1'b0;
		if (media_link_up) begin
			if (sel_r == SEL_MEDIA) begin
				good_ev = media_pkt_good;
				err_ev  = media_pkt_crc_err;
			end else if (sel_r == SEL_MAC) begin
				good_ev = mac_pkt_good;
				err_ev  = mac_pkt_crc_err;
			end
		end
	end

	// good counter: clear on read keeps a same-cycle packet
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			good_cnt_r <= '0;
		end else if (rd_good) begin
			good_cnt_r <= {{(GC_W-1){1'b0}}, good_ev};
		end else if (good_ev) begin
			if (good_cnt_r == GOOD_LAST) begin
				good_cnt_r <= '0;
			end else begin
				good_cnt_r <= good_cnt_r + 1'b1;
			end
		end
	end

	// error counter: saturates instead of wrapping
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			err_cnt_r <= '0;
		end else if (rd_err) begin
			err_cnt_r <= {{(EC_W-1){1'b0}}, err_ev};
		end else if (err_ev && err_cnt_r != ERR_MAX) begin
			err_cnt_r <= err_cnt_r + 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sticky flags: interrupt status (w1c) then read-cleared status bits
	assign flag_set[IB_REALIGN] = comma_realign;
	assign flag_set[IB_FAULT]   = far_end_fault_indication;
	assign flag_set[IB_HALT]    = halt_line_state;
	assign flag_set[IB_CRC_ERR] = err_ev;
	assign flag_set[IB_PKT]     = good_ev;
	assign flag_set[F_REALIGN]  = comma_realign;
	assign flag_set[F_SIGDET]   = signal_detect;
	assign flag_set[F_FAULT]    = far_end_fault_indication;
	assign flag_set[F_HALT]     = halt_line_state;
	assign flag_set[F_SINCE]    = good_ev;
	assign flag_clr = {rd_good, {4{rd_status}},
		{IRQ_W{wr_done & hit_i}} & pwdata[IRQ_W-1:0]};
	assign int_sts  = flag_q[IRQ_W-1:0];

	genvar gi;
	generate
		for (gi = 0; gi < NFLAG; gi++) begin : g_flag
			srsc_sticky u_flag (
				.clock      (clock),
				.rst_sync_b (rst_sync_b),
				.set        (flag_set[gi]),
				.clr        (flag_clr[gi]),
				.q          (flag_q[gi])
			);
		end
	endgenerate

	// interrupt mask and level output
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mask_r <= MSK_RST;
		end else if (wr_done && hit_m) begin
			mask_r <= pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_sts & mask_r);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_b);

	AST_PARTNER_CAPTURE: assert property (
		cw_valid |=> cw_r == $past(cw_data))
		else $error("partner code word not captured");

	AST_REALIGN_SET: assert property (
		comma_realign |=> flag_q[F_REALIGN])
		else $error("realign flag not set");

	AST_SIGDET_CLEAR: assert property (
		rd_status && !signal_detect |=> !flag_q[F_SIGDET])
		else $error("signal detect not cleared by read");

	AST_FAULT_HOLD: assert property (
		far_end_fault_indication ##1 !rd_status |=> flag_q[F_FAULT])
		else $error("far-end fault flag not held");

	AST_COMMA_READ: assert property (
		rd_status |=> comma_r)
		else $error("comma bit not set by read");

	AST_COMMA_DROP: assert property (
		!comma_detect && !rd_status |=> !comma_r)
		else $error("comma bit not cleared");

	AST_POS_TRACK: assert property (
		##1 pos_r == $past(comma_pos))
		else $error("comma position stale");

	AST_HALT_SET: assert property (
		halt_line_state |=> flag_q[F_HALT])
		else $error("halt line flag not set");

	AST_PKT_SINCE: assert property (
		rd_good && !good_ev |=> !flag_q[F_SINCE] && prdata[GC_SINCE] == $past(flag_q[F_SINCE]))
		else $error("packet-since bit wrong after read");

	AST_GOOD_WRAP: assert property (
		good_ev && !rd_good && good_cnt_r == GOOD_LAST |=> good_cnt_r == '0)
		else $error("good counter did not wrap");

	AST_GOOD_CLR: assert property (
		rd_good && !good_ev |=> good_cnt_r == '0 && prdata[GC_W-1:0] == $past(good_cnt_r))
		else $error("good counter read or clear wrong");

	AST_ERR_SAT: assert property (
		err_cnt_r == ERR_MAX && !rd_err |=> err_cnt_r == ERR_MAX)
		else $error("error counter left saturation");

	AST_SEL_LEGAL: assert property (
		sel_r == SEL_MEDIA || sel_r == SEL_MAC)
		else $error("reserved select code stored");

	AST_LINK_GATE: assert property (
		!media_link_up && !rd_good && !rd_err |=> $stable(good_cnt_r) && $stable(err_cnt_r))
		else $error("counter moved with link down");

	AST_RSVD_ZERO: assert property (
		prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
endmodule

// ==== verif/srsc_partner.sv ====
// fiber link partner model driving the serdes receive side
`timescale 1ns/1ps
module srsc_partner (
	input  wire logic clock,
	output logic        cw_valid,
	output logic [15:0] cw_data,
	output logic        comma_realign,
	output logic        signal_detect,
	output logic        far_end_fault_indication,
	output logic        comma_detect,
	output logic [3:0]  comma_pos,
	output logic        halt_line_state,
	output logic        media_link_up,
	output logic        media_pkt_good,
	output logic        media_pkt_crc_err,
	output logic        mac_pkt_good,
	output logic        mac_pkt_crc_err
);
	// idle line: link up, no events
	initial begin
		cw_valid = 1'b0;
		cw_data = 16'h0000;
		{comma_realign, signal_detect, far_end_fault_indication, halt_line_state} = 4'h0;
		comma_detect = 1'b0;
		comma_pos = 4'h0;
		media_link_up = 1'b1;
		{media_pkt_good, media_pkt_crc_err, mac_pkt_good, mac_pkt_crc_err} = 4'h0;
	end
	// code word; data inverted once valid drops so stale data never matches
	task automatic send_cw(input logic [15:0] w);
		@(posedge clock);
		cw_valid <= 1'b1;
		cw_data <= w;
		@(posedge clock);
		cw_valid <= 1'b0;
		cw_data <= ~w;
	endtask
	// one-cycle events: realign, signal detect, fault, halt
	task automatic events(input logic [3:0] e);
		@(posedge clock);
		{comma_realign, signal_detect, far_end_fault_indication, halt_line_state} <= e;
		@(posedge clock);
		{comma_realign, signal_detect, far_end_fault_indication, halt_line_state} <= 4'h0;
	endtask
	task automatic set_comma(input logic det, input logic [3:0] pos);
		@(posedge clock);
		comma_detect <= det;
		comma_pos <= pos;
	endtask
	task automatic link(input logic up);
		@(posedge clock);
		media_link_up <= up;
	endtask
	// k: 0 media good, 1 media error, 2 mac good, 3 mac error; back to back
	task automatic pkts(input logic [1:0] k, input int n);
		repeat (n) begin
			@(posedge clock);
			{media_pkt_good, media_pkt_crc_err, mac_pkt_good, mac_pkt_crc_err} <= 4'h8 >> k;
		end
		@(posedge clock);
		{media_pkt_good, media_pkt_crc_err, mac_pkt_good, mac_pkt_crc_err} <= 4'h0;
	endtask
endmodule

// ==== verif/srsc_top_test.sv ====
// self-checking bench for the serdes receive status block
`timescale 1ns/1ps
module srsc_top_test
	import srsc_pkg::*;
;
	logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d;
	logic        cw_valid, comma_realign, signal_detect, far_end_fault_indication, comma_detect;
	logic        halt_line_state, media_link_up, media_pkt_good, media_pkt_crc_err, mac_pkt_good, mac_pkt_crc_err;
	logic [15:0] cw_data;
	logic [3:0]  comma_pos;
	int          err_total = 0;
	int          check_count = 0;

	srsc_top i_dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
		.cw_valid, .cw_data, .comma_realign, .signal_detect, .far_end_fault_indication, .comma_detect, .comma_pos,
		.halt_line_state, .media_link_up, .media_pkt_good, .media_pkt_crc_err, .mac_pkt_good, .mac_pkt_crc_err);
	srsc_partner i_partner (.clock, .cw_valid, .cw_data, .comma_realign, .signal_detect, .far_end_fault_indication,
		.comma_detect, .comma_pos, .halt_line_state, .media_link_up, .media_pkt_good, .media_pkt_crc_err,
		.mac_pkt_good, .mac_pkt_crc_err);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one transfer; no wait count assumed, the watchdog ends a hang
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, WORD_ALIGN};
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock);
		while (pready !== 1'b1);
		d = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		cmp(d, exp);
	endtask
	task automatic irq_is(input logic exp);
		repeat (3) @(posedge clock);
		cmp({31'h0000_0000, irq}, {31'h0000_0000, exp});
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_basic;
		rd(IDX_GOOD, 32'h0000_0000);
		rd(IDX_ERROR, 32'h0000_0000);
		rd(IDX_STATUS, 32'h0000_0000);
		i_partner.send_cw(16'ha5c3);
		rd(IDX_PARTNER, 32'h0000_a5c3);
		apb(1'b1, IDX_PARTNER, 32'h0000_1234);
		rd(IDX_PARTNER, 32'h0000_a5c3);
		apb(1'b0, 6'h00, 32'h0000_0000);
		cmp({31'h0000_0000, er}, 32'h0000_0001);
		$display("reset, code word and unmapped done");
	endtask
	task automatic t_status;
		i_partner.set_comma(1'b1, 4'h9);
		i_partner.events(4'hf);
		rd(IDX_STATUS, 32'h0000_e980);
		rd(IDX_STATUS, 32'h0000_1900);
		i_partner.set_comma(1'b0, 4'h0);
		rd(IDX_STATUS, 32'h0000_0000);
		$display("status flags done");
	endtask
	task automatic t_counts;
		i_partner.pkts(2'h0, 3);
		rd(IDX_GOOD, 32'h0000_8003);
		rd(IDX_GOOD, 32'h0000_0000);
		i_partner.pkts(2'h0, 10001);
		rd(IDX_GOOD, 32'h0000_8001);
		i_partner.pkts(2'h1, 300);
		rd(IDX_ERROR, 32'h0000_00ff);
		rd(IDX_ERROR, 32'h0000_0000);
		$display("counters done");
	endtask
	// mac select, then a reserved code that must leave it alone
	task automatic t_select;
		apb(1'b1, IDX_ERROR, 32'h0000_4000);
		i_partner.pkts(2'h0, 2);
		i_partner.pkts(2'h2, 5);
		i_partner.pkts(2'h3, 1);
		rd(IDX_GOOD, 32'h0000_8005);
		apb(1'b1, IDX_ERROR, 32'h0000_8000);
		rd(IDX_ERROR, 32'h0000_4001);
		apb(1'b1, IDX_ERROR, 32'h0000_0000);
		i_partner.link(1'b0);
		i_partner.pkts(2'h0, 4);
		i_partner.pkts(2'h1, 2);
		rd(IDX_GOOD, 32'h0000_0000);
		rd(IDX_ERROR, 32'h0000_0000);
		i_partner.link(1'b1);
		$display("select and link done");
	endtask
	task automatic t_irq;
		apb(1'b1, IDX_INT_STS, 32'h0000_001f);
		i_partner.pkts(2'h0, 1);
		irq_is(1'b0);
		apb(1'b1, IDX_INT_MSK, 32'h0000_0010);
		irq_is(1'b1);
		rd(IDX_INT_STS, 32'h0000_0010);
		apb(1'b1, IDX_INT_STS, 32'h0000_0010);
		irq_is(1'b0);
		$display("interrupt done");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		t_basic;
		t_status;
		t_counts;
		t_select;
		t_irq;
		stop_test;
	end
	// watchdog: the run needs about 10400 cycles
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		stop_test;
	end
endmodule
